//--- rtl/smc_defines.vh
// Constants of the sleep-mode controller: register offsets, field positions,
// reset values and wake-up timing counts.
// Assumes a 100 MHz system clock and a 32-bit APB slave port.
`ifndef SMC_DEFINES_VH
`define SMC_DEFINES_VH

// Register byte offsets.
`define SMC_ADDR_POWER_CONTROL  12'h000
`define SMC_ADDR_COMPARATOR     12'h004
`define SMC_ADDR_WAKE_CONFIG    12'h008
`define SMC_ADDR_STATUS         12'h00c

// Field positions in the power control register.
`define SMC_BIT_SLEEP_ARM       7
`define SMC_MODE_HI             6
`define SMC_MODE_LO             4
// Field position in the comparator control register.
`define SMC_BIT_COMP_DISABLE    7
// Fields of the wake configuration register.
`define SMC_BIT_ASYNC_SELECT    0
`define SMC_BIT_CRYSTAL         1
`define SMC_FUSE_HI             5
`define SMC_FUSE_LO             2

// Reset values.
`define SMC_RST_POWER_CONTROL   8'h00
`define SMC_RST_COMPARATOR      8'h00
`define SMC_RST_WAKE_CONFIG     8'h00

// Sleep mode encodings.
`define SMC_MODE_IDLE           3'h0
`define SMC_MODE_ADC_NR         3'h1
`define SMC_MODE_PWR_DOWN       3'h2
`define SMC_MODE_PWR_SAVE       3'h3
`define SMC_MODE_STANDBY        3'h6
`define SMC_MODE_EXT_STANDBY    3'h7

// Timing counts in clock cycles.
`define SMC_HALT_CYCLES         8'h04
`define SMC_STANDBY_WAKE_CK     8'h06
`define SMC_PWR_WAKE_SHORT_CK   8'h06
`define SMC_PWR_WAKE_LONG_CK    8'h12

// Wake source vector bit positions.
`define SMC_SRC_EXT_EXT_LINE_2        0
`define SMC_SRC_EXT_LEVEL01     1
`define SMC_SRC_EXT_EDGE01      2
`define SMC_SRC_TWI_MATCH       3
`define SMC_SRC_TIMER2          4
`define SMC_SRC_SPM_EE          5
`define SMC_SRC_ADC             6
`define SMC_SRC_COMPARATOR      7
`define SMC_SRC_OTHER_IO        8
`define SMC_SRC_WIDTH           9

`endif

//--- rtl/smc_sleep_ctrl.v
// Sleep-mode controller: sleeps on an armed sleep instruction, gates clock domains
// per mode, qualifies wake sources, and times the wake-up and core halt.
// Assumes the core pulses sleep_exec_i for one cycle per sleep instruction
// and that interrupt requests arrive already synchronous to clk_i, except
// the external line requests, which are synchronised here.
//
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/1ns
`include "smc_defines.vh"

module smc_sleep_ctrl
(
  // Clock and reset.
  input  wire        clk_i,
  input  wire        rst_i,
  // APB slave port.
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [11:0] paddr_i,
  input  wire [31:0] pwdata_i,
  output wire        pready_o,
  output wire        pslverr_o,
  output reg  [31:0] prdata_o,
  // Core handshake.
  input  wire        sleep_exec_i,
  input  wire        sys_reset_req_i,
  input  wire        global_int_en_i,
  input  wire        adc_enabled_i,
  input  wire        timer2_ovf_en_i,
  input  wire        timer2_cmp_en_i,
  // Interrupt requests, each already gated by its own enable.
  input  wire [8:0]  wake_req_i,
  // Raw external line requests from pins.
  input  wire        ext_line_2_i,
  input  wire        ext_level_01_i,
  // Clock gates and controls.
  output reg         core_clock_en_o,
  output reg         program_memory_clock_en_o,
  output reg         peripheral_clock_en_o,
  output reg         converter_clock_en_o,
  output reg         async_timer_clock_en_o,
  output reg         main_osc_en_o,
  output reg         comparator_power_o,
  output reg         adc_start_o,
  output reg         core_halt_o,
  output reg         resume_next_o,
  output reg         restart_vector_o
);

  // Controller states.
  localparam [2:0] ST_RUN   = 3'h0;
  localparam [2:0] ST_SLEEP = 3'h1;
  localparam [2:0] ST_START = 3'h2;
  localparam [2:0] ST_HALT  = 3'h3;

  reg  [7:0] power_control_ff;   // Arm bit and mode select.
  reg  [7:0] comparator_ff;      // Comparator disable bit.
  reg  [7:0] wake_config_ff;     // Async select, crystal flag, start-up fuses.
  reg  [2:0] state_ff;           // Controller state.
  reg  [2:0] nxt_state;          // Next controller state.
  reg  [2:0] mode_ff;            // Mode latched at sleep entry.
  reg  [7:0] count_ff;           // Start-up and halt counter.
  reg  [7:0] nxt_count;          // Next counter value.
  reg        wake_is_reset_ff;   // Pending exit is a reset.
  reg  [1:0] ext_line_2_sync_ff;       // Synchroniser for line 2.
  reg  [1:0] lvl_sync_ff;        // Synchroniser for lines 0 and 1.

  wire [2:0] mode_sel   = power_control_ff[`SMC_MODE_HI:`SMC_MODE_LO];
  wire       sleep_arm  = power_control_ff[`SMC_BIT_SLEEP_ARM];
  wire       async_sel  = wake_config_ff[`SMC_BIT_ASYNC_SELECT];
  wire       crystal    = wake_config_ff[`SMC_BIT_CRYSTAL];
  wire [3:0] fuses      = wake_config_ff[`SMC_FUSE_HI:`SMC_FUSE_LO];
  wire       comp_off   = comparator_ff[`SMC_BIT_COMP_DISABLE];
  wire       apb_access = psel_i & penable_i;
  wire       apb_write  = apb_access & pwrite_i;

  // Without a crystal, standby falls back to power-down and extended standby to power-save behaviour.
  wire mode_reserved = (mode_sel == 3'h4) | (mode_sel == 3'h5);
  wire mode_standby  = (mode_ff == `SMC_MODE_STANDBY) | (mode_ff == `SMC_MODE_EXT_STANDBY);

  // The registers answer at once, so every access completes in one cycle.
  assign pready_o  = 1'b1;
  assign pslverr_o = 1'b0;

  // Two flip-flop synchronisers for the pin-driven external requests.
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ext_line_2_sync_ff <= 2'h0;
      lvl_sync_ff  <= 2'h0;
    end
    else
    begin
      ext_line_2_sync_ff <= {ext_line_2_sync_ff[0], ext_line_2_i};
      lvl_sync_ff  <= {lvl_sync_ff[0], ext_level_01_i};
    end
  end

  // Merge synchronised pin requests with the on-chip request vector.
  wire [8:0] req = wake_req_i |
                   {7'h00, lvl_sync_ff[1], ext_line_2_sync_ff[1]};

  // Per-mode allowed wake sources.
  reg [8:0] allow;
  always @*
  begin
    allow = 9'h000;
    case (mode_ff)
      `SMC_MODE_IDLE:
      begin
        allow = 9'h1ff;
        if (comp_off)
          allow[`SMC_SRC_COMPARATOR] = 1'b0;
      end
      `SMC_MODE_ADC_NR:
        allow = 9'h07b;
      `SMC_MODE_PWR_DOWN, `SMC_MODE_STANDBY:
        allow = 9'h00b;
      `SMC_MODE_PWR_SAVE, `SMC_MODE_EXT_STANDBY:
      begin
        allow = 9'h00b;
        allow[`SMC_SRC_TIMER2] = async_sel & global_int_en_i &
                                 (timer2_ovf_en_i | timer2_cmp_en_i);
      end
      default:
        allow = 9'h000;
    endcase
  end

  wire wake_int = |(req & allow);

  // Start-up delay: six for standby with a crystal, otherwise fuse-derived for power-down family.
  reg [7:0] startup_ck;
  always @*
  begin
    if (mode_ff == `SMC_MODE_IDLE || mode_ff == `SMC_MODE_ADC_NR)
      startup_ck = 8'h00;
    else if (mode_standby && crystal)
      startup_ck = `SMC_STANDBY_WAKE_CK;
    else if (fuses[3:1] == 3'h0)
      startup_ck = `SMC_PWR_WAKE_SHORT_CK;
    else
      startup_ck = `SMC_PWR_WAKE_LONG_CK;
  end

  // Sequencer next-state logic.
  always @*
  begin
    nxt_state = state_ff;
    nxt_count = count_ff;
    case (state_ff)
      ST_RUN:
      begin
        // An unarmed or reserved sleep leaves everything running.
        if (sleep_exec_i && sleep_arm && !mode_reserved)
          nxt_state = ST_SLEEP;
      end
      ST_SLEEP:
      begin
        if (sys_reset_req_i)
        begin
          nxt_state = ST_RUN;
        end
        else if (wake_int)
        begin
          nxt_state = (startup_ck == 8'h00) ? ST_HALT : ST_START;
          nxt_count = (startup_ck == 8'h00) ? `SMC_HALT_CYCLES : startup_ck;
        end
      end
      ST_START:
      begin
        if (count_ff == 8'h01)
        begin
          nxt_state = ST_HALT;
          nxt_count = `SMC_HALT_CYCLES;
        end
        else
          nxt_count = count_ff - 8'h01;
      end
      ST_HALT:
      begin
        if (count_ff == 8'h01)
          nxt_state = ST_RUN;
        else
          nxt_count = count_ff - 8'h01;
      end
      default:
        nxt_state = ST_RUN;
    endcase
  end

  // Sequencer state, mode latch and exit kind. Only control state lives
  // here; core storage is never touched, so its contents survive sleep.
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_ff         <= ST_RUN;
      count_ff         <= 8'h00;
      mode_ff          <= `SMC_MODE_IDLE;
      wake_is_reset_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      count_ff <= nxt_count;
      if (state_ff == ST_RUN && nxt_state == ST_SLEEP)
        mode_ff <= mode_sel;
      wake_is_reset_ff <= (state_ff == ST_SLEEP) & sys_reset_req_i;
    end
  end

  // Clock gating, converter start and exit pulses, all registered.
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      core_clock_en_o           <= 1'b1;
      program_memory_clock_en_o <= 1'b1;
      peripheral_clock_en_o     <= 1'b1;
      converter_clock_en_o      <= 1'b1;
      async_timer_clock_en_o    <= 1'b1;
      main_osc_en_o             <= 1'b1;
      comparator_power_o        <= 1'b1;
      adc_start_o               <= 1'b0;
      core_halt_o               <= 1'b0;
      resume_next_o             <= 1'b0;
      restart_vector_o          <= 1'b0;
    end
    else
    begin
      comparator_power_o <= ~comp_off;
      core_halt_o        <= (nxt_state != ST_RUN);
      resume_next_o      <= (state_ff == ST_HALT) & (nxt_state == ST_RUN);
      restart_vector_o   <= wake_is_reset_ff;
      // Converter starts once on entry into idle or noise mode.
      adc_start_o <= (state_ff == ST_RUN) & (nxt_state == ST_SLEEP) & adc_enabled_i &
                     ((mode_sel == `SMC_MODE_IDLE) | (mode_sel == `SMC_MODE_ADC_NR));
      if (state_ff == ST_SLEEP)
      begin
        core_clock_en_o           <= 1'b0;
        program_memory_clock_en_o <= 1'b0;
        peripheral_clock_en_o     <= (mode_ff == `SMC_MODE_IDLE);
        converter_clock_en_o      <= (mode_ff == `SMC_MODE_IDLE) |
                                     (mode_ff == `SMC_MODE_ADC_NR);
        async_timer_clock_en_o    <= (mode_ff == `SMC_MODE_IDLE) |
                                     (mode_ff == `SMC_MODE_ADC_NR) |
                                     (((mode_ff == `SMC_MODE_PWR_SAVE) |
                                       (mode_ff == `SMC_MODE_EXT_STANDBY)) & async_sel);
        // Standby keeps the oscillator only when a crystal is fitted.
        main_osc_en_o             <= (mode_ff == `SMC_MODE_IDLE) |
                                     (mode_ff == `SMC_MODE_ADC_NR) |
                                     (mode_standby & crystal);
      end
      else
      begin
        core_clock_en_o           <= 1'b1;
        program_memory_clock_en_o <= 1'b1;
        peripheral_clock_en_o     <= 1'b1;
        converter_clock_en_o      <= 1'b1;
        async_timer_clock_en_o    <= 1'b1;
        main_osc_en_o             <= 1'b1;
      end
    end
  end

  // Register writes take effect in the access cycle.
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      power_control_ff <= `SMC_RST_POWER_CONTROL;
      comparator_ff    <= `SMC_RST_COMPARATOR;
      wake_config_ff   <= `SMC_RST_WAKE_CONFIG;
    end
    else if (apb_write)
    begin
      case (paddr_i)
        `SMC_ADDR_POWER_CONTROL:
          power_control_ff <= pwdata_i[7:0];
        `SMC_ADDR_COMPARATOR:
          comparator_ff    <= pwdata_i[7:0];
        `SMC_ADDR_WAKE_CONFIG:
          wake_config_ff   <= pwdata_i[7:0];
        default:
          power_control_ff <= power_control_ff;
      endcase
    end
  end

  // Read mux; unmapped addresses read zero.
  always @*
  begin
    case (paddr_i)
      `SMC_ADDR_POWER_CONTROL:
        prdata_o = {24'h000000, power_control_ff};
      `SMC_ADDR_COMPARATOR:
        prdata_o = {24'h000000, comparator_ff};
      `SMC_ADDR_WAKE_CONFIG:
        prdata_o = {24'h000000, wake_config_ff};
      `SMC_ADDR_STATUS:
        prdata_o = {21'h000000, mode_ff, count_ff[4:0], state_ff};
      default:
        prdata_o = 32'h00000000;
    endcase
  end

endmodule // smc_sleep_ctrl

//--- dv/smc_core_model.sv
// Core and interrupt-source model facing the sleep-mode controller.
// Assumes bench commands change just after a rising edge.
`timescale 1ns/1ns
module smc_core_model
(
  // Clock and reset.
  input  wire       clk_i,
  input  wire       rst_i,
  // Bench commands.
  input  wire       sleep_cmd_i,
  input  wire [8:0] wake_cmd_i,
  // Controller side.
  input  wire       halt_i,
  output reg        sleep_exec_o,
  output reg  [8:0] wake_req_o
);
  // One sleep pulse per command; a request holds until the core runs.
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sleep_exec_o <= 1'b0;
      wake_req_o   <= 9'h000;
    end
    else
    begin
      sleep_exec_o <= sleep_cmd_i;
      // Dropping a level too early would lose the wake-up.
      if (wake_cmd_i != 9'h000)
        wake_req_o <= wake_cmd_i;
      else if (halt_i !== 1'b1)
        wake_req_o <= 9'h000;
    end
  end
endmodule // smc_core_model

//--- dv/smc_sleep_chk.sv
// Port checker for the sleep-mode controller.
// Assumes it is bound to smc_sleep_ctrl and sees only its ports.
`timescale 1ns/1ns
module smc_sleep_chk
(
  input wire clk_i,
  input wire rst_i,
  input wire psel_i,
  input wire penable_i,
  input wire pready_o,
  input wire pslverr_o,
  input wire sleep_exec_i,
  input wire sys_reset_req_i,
  input wire adc_enabled_i,
  input wire core_halt_o,
  input wire core_clock_en_o,
  input wire program_memory_clock_en_o,
  input wire peripheral_clock_en_o,
  input wire converter_clock_en_o,
  input wire main_osc_en_o,
  input wire adc_start_o,
  input wire resume_next_o,
  input wire restart_vector_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // An accepted sleep instruction: pulse, then halt.
  sequence s_enter;
    sleep_exec_i && !core_halt_o ##1 core_halt_o;
  endsequence
  apb_ready_a: assert property (psel_i && penable_i |-> pready_o && !pslverr_o)
    else $error("apb access not answered cleanly");
  enter_gate_a: assert property (s_enter |=> !core_clock_en_o && !program_memory_clock_en_o)
    else $error("core clocks still run after sleep");
  halt_cause_a: assert property ($rose(core_halt_o) |-> $past(sleep_exec_i))
    else $error("halt without sleep instruction");
  // The halt that ends in a resume pulse covers the four counted halt cycles.
  // Anchoring on the fall avoids any dependence on the start-up length.
  halt_hold_a: assert property ($fell(core_halt_o) && resume_next_o |-> $past(core_halt_o) && $past(core_halt_o, 2) && $past(core_halt_o, 3) && $past(core_halt_o, 4))
    else $error("halt shorter than four cycles");
  resume_at_a: assert property ($fell(core_halt_o) && !sys_reset_req_i |-> resume_next_o || $past(resume_next_o))
    else $error("halt ended without resume pulse");
  adc_cause_a: assert property (adc_start_o |-> $rose(core_halt_o) && $past(adc_enabled_i))
    else $error("converter start without sleep entry");
  osc_off_a: assert property (!main_osc_en_o |-> !peripheral_clock_en_o && !converter_clock_en_o)
    else $error("clocks run with oscillator off");
  peri_off_a: assert property (!peripheral_clock_en_o |-> !core_clock_en_o && !program_memory_clock_en_o)
    else $error("core clock runs with peripheral clock off");
  restart_cause_a: assert property (restart_vector_o |-> $past(sys_reset_req_i) || $past(sys_reset_req_i, 2)
    || $past(sys_reset_req_i, 3))
    else $error("restart without reset request");
endmodule // smc_sleep_chk
bind smc_sleep_ctrl smc_sleep_chk u_smc_sleep_chk (.*);

//--- dv/test_smc_sleep_ctrl.sv
// Self-checking bench for the sleep-mode controller.
// Assumes a core model drives sleep pulses and wake requests.
`timescale 1ns/1ns
module test_smc_sleep_ctrl;
  reg         clk_i = 1'b0;       // System clock.
  reg         rst_i = 1'b1;       // Reset, held at start.
  reg         psel_i = 1'b0;      // APB controls.
  reg         penable_i = 1'b0;
  reg         pwrite_i = 1'b0;
  reg  [11:0] paddr_i = 12'h000;
  reg  [31:0] pwdata_i = 32'h0;
  reg         sleep_cmd = 1'b0;   // Asks the model for a sleep.
  reg  [8:0]  wake_cmd = 9'h000;  // Asks the model for a wake request.
  reg         adc_en = 1'b0;
  reg         sys_rst_req = 1'b0;
  wire        sleep_exec, pready_o, pslverr_o, core_halt_o, resume_next_o, restart_vector_o;
  wire [8:0]  wake_req;
  wire [31:0] prdata_o;
  wire        core_en, prog_en, peri_en, conv_en, asy_en, osc_en, comp_pwr, adc_start;
  wire [5:0]  gates = {core_en, prog_en, peri_en, conv_en, asy_en, osc_en};
  integer     n_mismatch = 0;
  integer     check_count = 0;
  integer     seed = 25924;
  integer     adc_cnt = 0;
  integer     i, k, c0, k_idle;
  reg  [2:0]  m;
  reg         as2, arm;
  reg  [31:0] rd, wv;

  smc_sleep_ctrl u_smc_sleep_ctrl
  (
    .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .prdata_o(prdata_o), .sleep_exec_i(sleep_exec),
    .sys_reset_req_i(sys_rst_req), .global_int_en_i(1'b1), .adc_enabled_i(adc_en),
    .timer2_ovf_en_i(1'b1), .timer2_cmp_en_i(1'b1), .wake_req_i(wake_req),
    .ext_line_2_i(1'b0), .ext_level_01_i(1'b0), .core_clock_en_o(core_en),
    .program_memory_clock_en_o(prog_en), .peripheral_clock_en_o(peri_en),
    .converter_clock_en_o(conv_en), .async_timer_clock_en_o(asy_en), .main_osc_en_o(osc_en),
    .comparator_power_o(comp_pwr), .adc_start_o(adc_start), .core_halt_o(core_halt_o),
    .resume_next_o(resume_next_o), .restart_vector_o(restart_vector_o)
  );

  smc_core_model u_smc_core_model
  (
    .clk_i(clk_i), .rst_i(rst_i), .sleep_cmd_i(sleep_cmd), .wake_cmd_i(wake_cmd),
    .halt_i(core_halt_o), .sleep_exec_o(sleep_exec), .wake_req_o(wake_req)
  );

  always #5 clk_i = ~clk_i;

  // Counts converter start pulses; each lasts one cycle.
  always @(posedge clk_i)
    if (adc_start === 1'b1)
      adc_cnt <= adc_cnt + 1;

  // Expected clock enables {core, program, peripheral, converter, async, osc}.
  function [5:0] exp_gates(input [2:0] md, input a2);
    case (md)
      3'h0: exp_gates = 6'h0f;
      3'h1: exp_gates = 6'h07;
      3'h2: exp_gates = 6'h00;
      3'h3: exp_gates = {4'h0, a2, 1'b0};
      3'h6: exp_gates = 6'h01;
      3'h7: exp_gates = {4'h0, a2, 1'b1};
      default: exp_gates = 6'h3f; // Reserved codes never sleep.
    endcase
  endfunction

  task chk(input string nm, input [31:0] exp, input [31:0] got);
    check_count = check_count + 1;
    if (got !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task wrap_up;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task tmo;
    n_mismatch = n_mismatch + 1;
    $display("wrong value wait expected 1 seen 0");
    wrap_up;
  endtask

  // One APB transfer; read data is taken at the ready edge.
  task apb(input w, input [11:0] a, input [31:0] d);
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    @(posedge clk_i);
    for (k = 0; pready_o !== 1'b1 && k < 20; k = k + 1)
      @(posedge clk_i);
    if (k == 20)
      tmo;
    rd = prdata_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task sleep;
    @(posedge clk_i);
    sleep_cmd <= 1'b1;
    @(posedge clk_i);
    sleep_cmd <= 1'b0;
    repeat (5) @(posedge clk_i);
    #1;
  endtask

  initial
  begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    // Reset values, then an unmapped address, all read zero.
    for (i = 0; i < 4; i = i + 1)
    begin
      apb(1'b0, (i == 3) ? 12'h020 : {i[9:0], 2'b00}, 32'h0);
      chk("reset value", 32'h0, rd);
    end
    apb(1'b1, 12'h004, 32'h80);
    repeat (2) @(posedge clk_i);
    #1;
    chk("comparator power", 32'h0, comp_pwr);
    apb(1'b1, 12'h004, 32'h0);
    // Every mode code, then one unarmed sleep (pass 8).
    for (i = 0; i < 9; i = i + 1)
    begin
      m = i[2:0];
      arm = (i < 8);
      rd = $random(seed);
      as2 = rd[0];
      adc_en <= rd[1];
      wv = {24'h0, arm, m, rd[7:4]};
      apb(1'b1, 12'h008, {30'h0, 1'b1, as2});
      apb(1'b1, 12'h000, wv);
      c0 = adc_cnt;
      sleep;
      chk("gates", arm ? exp_gates(m, as2) : 6'h3f, gates);
      chk("adc starts", arm && m < 3'h2 && adc_en, adc_cnt - c0);
      if (arm && m != 3'h4 && m != 3'h5)
      begin
        @(posedge clk_i);
        if (m != 3'h0)
          wake_cmd <= 9'h100;
        repeat (20) @(posedge clk_i);
        #1;
        chk("halt held", 32'h1, core_halt_o);
        @(posedge clk_i);
        wake_cmd <= 9'h008;
        // Look one step after each edge so the registered pulse has settled.
        for (k = 0; resume_next_o !== 1'b1 && k < 200; k = k + 1)
        begin
          @(posedge clk_i);
          #1;
        end
        if (k == 200)
          tmo;
        wake_cmd <= 9'h000;
        if (m == 3'h0)
          k_idle = k;
        chk("start-up extra", (m < 3'h2) ? 6 - 6 : 6, k - k_idle);
        repeat (3) @(posedge clk_i);
        #1;
        chk("awake gates", 32'h3f, gates);
        apb(1'b0, 12'h000, 32'h0);
        chk("control kept", wv, rd);
      end
      $display("test %0d done", i);
    end
    // A reset request wakes power-down through the restart path.
    apb(1'b1, 12'h000, 32'ha0);
    sleep;
    sys_rst_req <= 1'b1;
    for (k = 0; restart_vector_o !== 1'b1 && k < 200; k = k + 1)
    begin
      @(posedge clk_i);
      #1;
    end
    if (k == 200)
      tmo;
    sys_rst_req <= 1'b0;
    repeat (3) @(posedge clk_i);
    #1;
    chk("reset wake gates", 32'h3f, gates);
    $display("test reset wake done");
    wrap_up;
  end
endmodule // test_smc_sleep_ctrl
